// [rtl/dtp_pkg.sv]
// Package with register map, field layout, reset values and timing constants of the timer block.
package dtp_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [2:0] IDX_TIMER_COUNT      = 3'h0;
	localparam logic [2:0] IDX_TIMER_CTRL_ONE   = 3'h1;
	localparam logic [2:0] IDX_TIMER_CTRL_TWO   = 3'h2;
	localparam logic [2:0] IDX_PWM_DUTY         = 3'h3;
	localparam logic [2:0] IDX_PRESCALER_COUNT  = 3'h4;
	localparam logic [2:0] IDX_BUZZER_CTRL      = 3'h5;
	localparam logic [2:0] IDX_IR_CTRL          = 3'h6;
	localparam logic [2:0] IDX_TIMER_STATUS     = 3'h7;

	// Field positions in timer_control_one.
	localparam int POS_TIMER_ENABLE      = 0;
	localparam int POS_RELOAD_SELECT     = 1;
	localparam int POS_ONE_SHOT_SELECT   = 2;
	localparam int POS_PWM_POLARITY      = 6;
	localparam int POS_PWM_OUTPUT_ENABLE = 7;

	// Field positions in timer_control_two.
	localparam int POS_PRESCALER_RATE    = 0;
	localparam int POS_PRESCALER_ENABLE_N = 3;
	localparam int POS_EXT_EDGE_SELECT   = 4;
	localparam int POS_CLOCK_SOURCE_SEL  = 5;

	// Field positions in buzzer_control, ir_control and the status register.
	localparam int POS_BUZZER_FREQ_SEL   = 0;
	localparam int POS_BUZZER_ENABLE     = 7;
	localparam int POS_IR_ENABLE         = 0;
	localparam int POS_IR_FREQ_SELECT    = 1;
	localparam int POS_IR_POLARITY       = 2;
	localparam int POS_UNDERFLOW_FLAG    = 0;

	// Readable bits of the two timer control registers; the others read as zero.
	localparam logic [7:0] RD_MASK_CTRL_ONE = 8'h07;
	localparam logic [7:0] RD_MASK_CTRL_TWO = 8'h3f;

	// Reset values, plus the counter's wrap and zero values.
	localparam logic [7:0] RST_TIMER_COUNT     = 8'h00;
	localparam logic [7:0] RST_TIMER_CTRL_ONE  = 8'h00;
	localparam logic [7:0] RST_TIMER_CTRL_TWO  = 8'h3f;
	localparam logic [7:0] RST_PWM_DUTY        = 8'h00;
	localparam logic [7:0] RST_PRESCALER_COUNT = 8'hff;
	localparam logic [7:0] RST_BUZZER_CTRL     = 8'h0f;
	localparam logic [7:0] RST_IR_CTRL         = 8'h00;
	localparam logic [7:0] TIMER_WRAP_VALUE    = 8'hff;
	localparam logic [7:0] TIMER_ZERO          = 8'h00;

	// Timing: system clock, carrier reference and carrier division ratios.
	localparam int MCLK_HZ       = 20_000_000;
	localparam int HOSC_HZ       = 4_000_000;
	localparam int HOSC_DIV      = MCLK_HZ / HOSC_HZ;
	localparam int IR_DIV_HIGH   = 64;
	localparam int IR_DIV_LOW    = 96;
	localparam int INST_DIV      = 2;

	// A pin driven by this block: level and output enable travel together.
	typedef struct packed {
		logic out;
		logic oe;
	} dtp_pin_s;

endpackage

// [rtl/dtp_timer.sv]
// Down timer with prescaler, PWM, buzzer and IR carrier generator behind an APB slave.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps

// Operation
// RQ1 - Count register read returns live counter.
// RQ2 - Count write loads reload and counter.
// RQ3 - Timer counts only while enable is set.
// RQ4 - Non-stop, reload-select 0: wrap to 0xff.
// RQ5 - Non-stop, reload-select 1: reload stored value.
// RQ6 - One-shot counts once to zero, stops.
// RQ7 - PWM polarity bit 1 means active low.
// RQ8 - PWM enable puts waveform on pin two.
// RQ9 - Prescaler divides by two to power code+1.
// RQ10 - Prescaler bypassed while its enable_n is set.
// RQ11 - Edge select: 1 falling, 0 rising edges.
// RQ12 - Clock source: instruction clock or external pin.
// RQ13 - PWM inactive until count equals duty.
// RQ14 - Reload sets PWM period, duty sets duty.
// RQ15 - Prescaler value read live, resets all ones.
// RQ16 - Buzzer picks prescaler tap or timer bit.
// RQ17 - IR carrier only while IR enable set.
// RQ18 - IR select: 1 gives 57 kHz, 0 38; the code gives 62.5 kHz and about 41.7 kHz.
// RQ19 - IR polarity decides data level gating carrier.
// RQ20 - IR runs from 4 MHz reference, 64/96.
// RQ21 - Underflow sets sticky flag until cleared.
// RQ22 - IR carrier appears on pin one.
// RQ23 - Disabled timer holds and makes no underflow.
module dtp_timer
	import dtp_pkg::*;
#(
	parameter int INST_DIVIDE = INST_DIV
)
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_clock_pin,
	input  wire dtp_pin_s    gpio_pin_one,
	input  wire dtp_pin_s    gpio_pin_two,
	output dtp_pin_s         shared_port_pin_one,
	output dtp_pin_s         shared_port_pin_two,
	output logic             underflow_flag
);

	localparam int IR_HALF_HIGH = IR_DIV_HIGH / 2;
	localparam int IR_HALF_LOW  = IR_DIV_LOW / 2;

	logic [7:0]  timer_count_ff;
	logic [7:0]  nxt_timer_count;
	logic [7:0]  reload_ff;
	logic [7:0]  ctrl_one_ff;
	logic [7:0]  ctrl_two_ff;
	logic [7:0]  pwm_duty_ff;
	logic [7:0]  presc_ff;
	logic [7:0]  buzzer_ctrl_ff;
	logic [7:0]  ir_ctrl_ff;
	logic        underflow_flag_ff;
	logic        stopped_ff;
	logic        enable_d_ff;
	logic        pwm_active_ff;
	logic        buzzer_level;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        ext_sync1_ff;
	logic        ext_sync2_ff;
	logic        ext_prev_ff;
	logic [7:0]  inst_cnt_ff;
	logic        inst_tick;
	logic        ext_edge;
	logic        src_tick;
	logic        presc_tick;
	logic        timer_tick;
	logic        underflow;
	logic [2:0]  hosc_cnt_ff;
	logic        hosc_tick;
	logic [6:0]  ir_cnt_ff;
	logic        ir_carrier_ff;
	logic        ir_gate;
	dtp_pin_s    pin_one_ff;
	dtp_pin_s    pin_two_ff;

	logic        reg_valid;
	logic [2:0]  reg_idx;
	logic        wr_en;
	logic        timer_enable;
	logic [2:0]  presc_rate;

	// True when the bus address names one of the eight word-aligned registers.
	function automatic logic addr_hit(input logic [31:0] addr);
		addr_hit = (addr[31:5] == 27'h0) && (addr[1:0] == 2'h0);
	endfunction

	assign reg_valid    = addr_hit(paddr);
	assign reg_idx      = paddr[4:2];
	assign wr_en        = psel && penable && pready_ff && pwrite && reg_valid;
	assign timer_enable = ctrl_one_ff[POS_TIMER_ENABLE];
	assign presc_rate   = ctrl_two_ff[POS_PRESCALER_RATE +: 3];

	// The slave answers with one registered cycle so that every bus output comes from a flop.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff  <= psel && !penable;
			pslverr_ff <= psel && !penable && !reg_valid;
		end
	end

	// Read data is captured in the setup cycle, the moment of the read.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			prdata_ff <= 32'h0;
		else if (psel && !penable && !pwrite && reg_valid)
		begin
			case (reg_idx)
				IDX_TIMER_COUNT:     prdata_ff <= {24'h0, timer_count_ff}; // RQ1
				IDX_TIMER_CTRL_ONE:  prdata_ff <= {24'h0, ctrl_one_ff & RD_MASK_CTRL_ONE};
				IDX_TIMER_CTRL_TWO:  prdata_ff <= {24'h0, ctrl_two_ff & RD_MASK_CTRL_TWO};
				IDX_PRESCALER_COUNT: prdata_ff <= {24'h0, presc_ff}; // RQ15
				IDX_TIMER_STATUS:    prdata_ff <= {31'h0, underflow_flag_ff};
				default:             prdata_ff <= 32'h0;
			endcase
		end
		// Any setup that is not a mapped read clears stale data, so a refused access reads zero.
		else if (!penable)
			prdata_ff <= 32'h0;
	end

	// Control registers written by software.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_one_ff    <= RST_TIMER_CTRL_ONE;
			ctrl_two_ff    <= RST_TIMER_CTRL_TWO;
			pwm_duty_ff    <= RST_PWM_DUTY;
			buzzer_ctrl_ff <= RST_BUZZER_CTRL;
			ir_ctrl_ff     <= RST_IR_CTRL;
		end
		else if (wr_en)
		begin
			case (reg_idx)
				IDX_TIMER_CTRL_ONE: ctrl_one_ff    <= pwdata[7:0];
				IDX_TIMER_CTRL_TWO: ctrl_two_ff    <= pwdata[7:0];
				IDX_PWM_DUTY:       pwm_duty_ff    <= pwdata[7:0]; // RQ14
				IDX_BUZZER_CTRL:    buzzer_ctrl_ff <= pwdata[7:0];
				IDX_IR_CTRL:        ir_ctrl_ff     <= pwdata[7:0];
				default:            ctrl_one_ff    <= ctrl_one_ff;
			endcase
		end
	end

	// External clock pin crosses into mclk through two flops before the edge detector.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			ext_sync1_ff <= 1'b0;
			ext_sync2_ff <= 1'b0;
			ext_prev_ff  <= 1'b0;
		end
		else
		begin
			ext_sync1_ff <= ext_clock_pin;
			ext_sync2_ff <= ext_sync1_ff;
			ext_prev_ff  <= ext_sync2_ff;
		end
	end

	// Edge select picks falling or rising transitions of the pin.
	assign ext_edge = ctrl_two_ff[POS_EXT_EDGE_SELECT] ? (ext_prev_ff && !ext_sync2_ff)
		: (!ext_prev_ff && ext_sync2_ff); // RQ11

	// Instruction clock is a divided enable of mclk.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			inst_cnt_ff <= 8'h0;
		else if (inst_tick)
			inst_cnt_ff <= 8'h0;
		else
			inst_cnt_ff <= inst_cnt_ff + 8'h1;
	end

	assign inst_tick = (inst_cnt_ff == 8'(INST_DIVIDE - 1));
	assign src_tick  = ctrl_two_ff[POS_CLOCK_SOURCE_SEL] ? ext_edge : inst_tick; // RQ12

	// The prescaler counts down; tap k toggles every 2 to the k source ticks.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			presc_ff <= RST_PRESCALER_COUNT; // RQ15
		else if (src_tick && timer_enable)
			presc_ff <= presc_ff - 8'h1;
	end

	// A division of 2^(code+1) ends when the low code+1 bits reach zero.
	assign presc_tick = src_tick && timer_enable
		&& ((presc_ff & ((8'h2 << presc_rate) - 8'h1)) == 8'h0); // RQ9
	// Changing the rate with the prescaler live can cut a period short; hence the bypass.
	assign timer_tick = ctrl_two_ff[POS_PRESCALER_ENABLE_N] ? src_tick : presc_tick; // RQ10

	assign underflow = timer_tick && timer_enable && !stopped_ff
		&& (timer_count_ff == TIMER_ZERO);

	always_comb
	begin
		nxt_timer_count = timer_count_ff;
		if (timer_tick && timer_enable && !stopped_ff) // RQ3 RQ23
		begin
			if (timer_count_ff != TIMER_ZERO)
				nxt_timer_count = timer_count_ff - 8'h1;
			else if (ctrl_one_ff[POS_ONE_SHOT_SELECT])
				nxt_timer_count = TIMER_ZERO; // RQ6
			else if (ctrl_one_ff[POS_RELOAD_SELECT])
				nxt_timer_count = reload_ff; // RQ5 RQ14
			else
				nxt_timer_count = TIMER_WRAP_VALUE; // RQ4
		end
	end

	// A count write loads both counter and reload value and rearms a finished one-shot.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			timer_count_ff <= RST_TIMER_COUNT;
			reload_ff      <= RST_TIMER_COUNT;
			stopped_ff     <= 1'b0;
		end
		else if (wr_en && (reg_idx == IDX_TIMER_COUNT))
		begin
			timer_count_ff <= pwdata[7:0]; // RQ2
			reload_ff      <= pwdata[7:0]; // RQ2
			stopped_ff     <= 1'b0;
		end
		else
		begin
			timer_count_ff <= nxt_timer_count;
			if (underflow && ctrl_one_ff[POS_ONE_SHOT_SELECT])
				stopped_ff <= 1'b1; // RQ6
			else if (!ctrl_one_ff[POS_ONE_SHOT_SELECT])
				stopped_ff <= 1'b0;
		end
	end

	// Underflow flag is sticky; a write of one clears it, but a new underflow wins.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			underflow_flag_ff <= 1'b0;
		else if (underflow)
			underflow_flag_ff <= 1'b1; // RQ21
		else if (wr_en && (reg_idx == IDX_TIMER_STATUS) && pwdata[POS_UNDERFLOW_FLAG])
			underflow_flag_ff <= 1'b0;
	end

	// PWM goes active on duty match and returns inactive on underflow or on enable.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			enable_d_ff   <= 1'b0;
			pwm_active_ff <= 1'b0;
		end
		else
		begin
			enable_d_ff <= timer_enable;
			if ((timer_enable && !enable_d_ff) || underflow)
				pwm_active_ff <= 1'b0; // RQ13
			else if (timer_enable && (nxt_timer_count == pwm_duty_ff))
				pwm_active_ff <= 1'b1; // RQ13 RQ14
		end
	end

	// Buzzer taps a prescaler bit or a timer count bit.
	always_comb
	begin
		if (buzzer_ctrl_ff[POS_BUZZER_FREQ_SEL + 3])
			buzzer_level = timer_count_ff[buzzer_ctrl_ff[POS_BUZZER_FREQ_SEL +: 3]]; // RQ16
		else
			buzzer_level = presc_ff[buzzer_ctrl_ff[POS_BUZZER_FREQ_SEL +: 3]]; // RQ16
	end

	// The 4 MHz reference is an enable derived from mclk.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			hosc_cnt_ff <= 3'h0;
		else if (hosc_tick)
			hosc_cnt_ff <= 3'h0;
		else
			hosc_cnt_ff <= hosc_cnt_ff + 3'h1;
	end

	assign hosc_tick = (hosc_cnt_ff == 3'(HOSC_DIV - 1)); // RQ20

	// Carrier toggles every half ratio of reference ticks, giving 64 or 96 per period.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			ir_cnt_ff     <= 7'h0;
			ir_carrier_ff <= 1'b0;
		end
		else if (!ir_ctrl_ff[POS_IR_ENABLE])
		begin
			ir_cnt_ff     <= 7'h0; // RQ17
			ir_carrier_ff <= 1'b0;
		end
		else if (hosc_tick)
		begin
			// A count already past the limit after a frequency change ends the half period at once.
			if (ir_cnt_ff >= (ir_ctrl_ff[POS_IR_FREQ_SELECT] ? 7'(IR_HALF_HIGH - 1)
				: 7'(IR_HALF_LOW - 1))) // RQ18 RQ20
			begin
				ir_cnt_ff     <= 7'h0;
				ir_carrier_ff <= !ir_carrier_ff;
			end
			else
				ir_cnt_ff <= ir_cnt_ff + 7'h1;
		end
	end

	assign ir_gate = gpio_pin_one.out ^ ir_ctrl_ff[POS_IR_POLARITY]; // RQ19

	// Pin multiplexers; PWM takes pin two ahead of the buzzer when both are enabled.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_one_ff <= '0;
			pin_two_ff <= '0;
		end
		else
		begin
			if (ir_ctrl_ff[POS_IR_ENABLE])
				pin_one_ff <= '{out: ir_carrier_ff && ir_gate, oe: 1'b1}; // RQ22
			else
				pin_one_ff <= gpio_pin_one;
			if (ctrl_one_ff[POS_PWM_OUTPUT_ENABLE])
				pin_two_ff <= '{out: pwm_active_ff ^ ctrl_one_ff[POS_PWM_POLARITY],
					oe: 1'b1}; // RQ7 RQ8
			else if (buzzer_ctrl_ff[POS_BUZZER_ENABLE])
				pin_two_ff <= '{out: buzzer_level, oe: 1'b1}; // RQ16
			else
				pin_two_ff <= gpio_pin_two; // RQ8
		end
	end

	assign prdata              = prdata_ff;
	assign pready              = pready_ff;
	assign pslverr             = pslverr_ff;
	assign shared_port_pin_one = pin_one_ff;
	assign shared_port_pin_two = pin_two_ff;
	assign underflow_flag      = underflow_flag_ff;

endmodule

// [bench/dtp_timer_assertions.sv]
// Checker for the timer block's bus answers, read masks and sticky flag.
`timescale 1ns/1ps
module dtp_timer_assertions
	import dtp_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        underflow_flag
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence
	property p_ready;
		s_setup |=> pready ##1 !pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready not one cycle");
	property p_idle;
		!psel |=> !pready;
	endproperty
	a_idle: assert property (p_idle) else $error("pready without psel");
	property p_err;
		s_setup ##0 (paddr[31:5] != 27'h0 || paddr[1:0] != 2'h0) |=> pslverr && prdata == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_ok;
		s_setup ##0 (paddr[31:5] == 27'h0 && paddr[1:0] == 2'h0) |=> !pslverr;
	endproperty
	a_ok: assert property (p_ok) else $error("mapped access refused");
	property p_upper;
		s_done |-> prdata[31:8] == 24'h0;
	endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	// The polarity and pin enable bits are write-only, so they must read as zero.
	property p_ctrl1;
		s_done ##0 (!pwrite && paddr == 32'h4) |-> prdata[7:3] == 5'h0;
	endproperty
	a_ctrl1: assert property (p_ctrl1) else $error("control one mask");
	property p_ctrl2;
		s_done ##0 (!pwrite && paddr == 32'h8) |-> prdata[7:6] == 2'h0;
	endproperty
	a_ctrl2: assert property (p_ctrl2) else $error("control two mask");
	property p_flag;
		underflow_flag && !(psel && penable && pready && pwrite && paddr == 32'h1c && pwdata[0])
			|=> underflow_flag;
	endproperty
	a_flag: assert property (p_flag) else $error("flag dropped by itself");
endmodule

// [bench/dtp_load_model.sv]
// Pin load model: counts rising edges on the driven pins and high time on pin two, makes external clock edges.
`timescale 1ns/1ps
module dtp_load_model
	import dtp_pkg::*;
(
	input  wire logic     mclk,
	input  wire logic     clr,
	input  wire dtp_pin_s pin_one,
	input  wire dtp_pin_s pin_two,
	output int            rise_one,
	output int            rise_two,
	output int            high_two,
	output logic          ext_clk
);
	logic l1;
	logic l2;
	initial ext_clk = 1'b0;
	// A load only sees a level while the pin is actually driven.
	always @(posedge mclk)
	begin
		l1 <= pin_one.out && pin_one.oe;
		l2 <= pin_two.out && pin_two.oe;
		rise_one <= clr ? 0 : rise_one + int'(pin_one.out && pin_one.oe && !l1);
		rise_two <= clr ? 0 : rise_two + int'(pin_two.out && pin_two.oe && !l2);
		high_two <= clr ? 0 : high_two + int'(pin_two.out && pin_two.oe);
	end
	task automatic toggle(input int n);
		repeat (n)
		begin
			repeat (8) @(posedge mclk);
			ext_clk <= ~ext_clk;
		end
	endtask
endmodule

// [bench/dtp_timer_tb.sv]
// Testbench of the timer block: bus access, counting modes and pin outputs.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module dtp_timer_tb
	import dtp_pkg::*;
;
	logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, flag, ext, clr, rerr;
	logic [31:0] paddr, pwdata, prdata, rdat;
	dtp_pin_s    gp1, gp2, sp1, sp2;
	int          err_total, checked, r1, r2, h2, ex;
	dtp_timer i_dtp_timer (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_clock_pin(ext), .gpio_pin_one(gp1), .gpio_pin_two(gp2),
		.shared_port_pin_one(sp1), .shared_port_pin_two(sp2), .underflow_flag(flag));
	dtp_load_model i_dtp_load_model (.mclk(mclk), .clr(clr), .pin_one(sp1), .pin_two(sp2),
		.rise_one(r1), .rise_two(r2), .high_two(h2), .ext_clk(ext));
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input int i, input logic [7:0] d);
		apb(1'b1, 32'(i * 4), d);
	endtask
	task automatic rd(input int i);
		apb(1'b0, 32'(i * 4), 8'h0);
	endtask
	task automatic run(input logic [7:0] c, input int n);
		wr(1, c);
		cyc(n);
		wr(1, 8'h0);
		rd(0);
	endtask
	task automatic window(input int n);
		clr <= 1'b1;
		cyc(1);
		clr <= 1'b0;
		cyc(n);
	endtask
	task automatic in_range(input logic signed [31:0] v, input int lo, input int hi);
		`CHK(v >= lo && v <= hi, 1'b1)
	endtask
	task automatic print_verdict();
		$display("checked %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		cyc(80000);
		err_total++;
		print_verdict();
	end
	initial
	begin
		int         ri[5] = '{0, 1, 2, 4, 7};
		logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h3f, 8'hff, 8'h00};
		logic [7:0] ic[5] = '{8'h01, 8'h03, 8'h05, 8'h05, 8'h00};
		logic       gv[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		int         ie[5] = '{10, 15, 0, 10, 0};
		logic [7:0] d;
		{rstn, psel, penable, pwrite, clr, paddr, pwdata, gp1, gp2} = '0;
		d = 8'($urandom(22639));
		cyc(2);
		rstn <= 1'b1;
		foreach (ri[i])
		begin
			rd(ri[i]);
			`CHK(rdat, {24'h0, rv[i]})
		end
		wr(4, 8'h00);
		rd(4);
		`CHK(rdat, 32'hff)
		apb(1'b0, 32'h20, 8'h0);
		`CHK(rerr, 1'b1)
		apb(1'b1, 32'h2, 8'h0);
		`CHK(rerr, 1'b1)
		wr(0, d);
		cyc(20);
		rd(0);
		`CHK(rdat, {24'h0, d})
		wr(2, 8'h08);
		wr(0, 8'h02);
		run(8'h01, 20);
		in_range(rdat, 8'hf4, 8'hf8);
		wr(0, 8'h10);
		run(8'h03, 40);
		in_range(rdat, 9, 14);
		wr(7, 8'h01);
		wr(0, 8'h05);
		run(8'h07, 40);
		`CHK(rdat, 32'h0)
		`CHK(flag, 1'b1)
		wr(7, 8'h01);
		rd(7);
		`CHK(rdat, 32'h0)
		for (int e = 0; e < 8; e++)
		begin
			wr(2, 8'h08 | 8'(e));
			wr(2, 8'(e));
			wr(0, 8'h80);
			run(8'h01, 16 << e);
			in_range(rdat, 8'h7a, 8'h7d);
		end
		wr(2, 8'h0f);
		// Five toggles give three edges of the chosen kind but only two of the other.
		for (int e = 0; e < 2; e++)
		begin
			wr(2, 8'h28 | 8'(e << 4));
			wr(0, 8'h40);
			wr(1, 8'h01);
			i_dtp_load_model.toggle(5);
			cyc(10);
			wr(1, 8'h0);
			rd(0);
			`CHK(rdat, 32'h3d)
		end
		wr(2, 8'h08);
		wr(3, 8'h03);
		wr(0, 8'h0f);
		for (int e = 0; e < 2; e++)
		begin
			wr(1, 8'h83 | 8'(e << 6));
			window(320);
			ex = e ? 240 : 80;
			in_range(h2, ex - 8, ex + 8);
		end
		wr(1, 8'h0);
		gp2 <= 2'($urandom);
		cyc(3);
		`CHK(sp2.out, gp2.out)
		for (int e = 0; e < 16; e++)
		begin
			wr(2, 8'h0f);
			if (e < 8)
				wr(2, 8'h07);
			wr(5, 8'h80 | 8'(e));
			wr(1, 8'h01);
			window(1024);
			ex = 1024 >> (e % 8 + 2);
			in_range(r2, ex - 1, ex + 1);
			wr(1, 8'h0);
		end
		foreach (ic[i])
		begin
			gp1 <= '{out: gv[i], oe: 1'b1};
			wr(6, ic[i]);
			window(4800);
			in_range(r1, ie[i] - 1, ie[i] + 1);
		end
		print_verdict();
	end
endmodule
bind dtp_timer dtp_timer_assertions i_dtp_timer_assertions (.mclk(mclk), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .underflow_flag(underflow_flag));
